// ==== core/spsup_consts.svh ====
// Register offsets, field positions, reset values and counts of the position supervisor.
`ifndef SPSUP_CONSTS_SVH
`define SPSUP_CONSTS_SVH

// Width of the byte address seen on the register bus.
`define SPSUP_ADDR_W 6
// Byte offsets of the registers.
`define SPSUP_REG_CTRL 6'h00
`define SPSUP_REG_CMD 6'h04
`define SPSUP_REG_TIME0 6'h08
`define SPSUP_REG_TIME3 6'h14
`define SPSUP_REG_STATUS 6'h18
`define SPSUP_REG_IRQ_STAT 6'h1C
`define SPSUP_REG_IRQ_MASK 6'h20
// Control register: per unit u, wiring bits at 4*u, protection routing and assembly mode.
`define SPSUP_CTRL_W 10
`define SPSUP_CTRL_RST 10'h033
`define SPSUP_CTRL_UNIT_STRIDE 4
`define SPSUP_CTRL_ON_WIRED 0
`define SPSUP_CTRL_OFF_WIRED 1
`define SPSUP_CTRL_ROUTE 8
`define SPSUP_CTRL_ASSY 9
// Command register: per unit u, close at 2*u and open at 2*u+1.
`define SPSUP_CMD_W 4
// Travel time registers hold clock ticks; index 2*u is close, 2*u+1 is open.
`define SPSUP_TIME_N 4
`define SPSUP_TIME_RST 32'h0000_1000
// Status register: per unit u, a byte at 8*u, plug flag above.
`define SPSUP_STAT_UNIT_STRIDE 8
`define SPSUP_STAT_PLUG 16
// Interrupt bits: per unit u, success at 2*u and failure at 2*u+1, plug change last.
`define SPSUP_IRQ_W 5
`define SPSUP_IRQ_PLUG 4

`endif

// ==== core/spsup_pkg.sv ====
// Types shared by the position supervisor modules.
package spsup_pkg;
	// Validated position code of a switching unit.
	typedef enum logic [1:0] {
		SPSUP_POS_INDET = 2'h0,
		SPSUP_POS_OFF = 2'h1,
		SPSUP_POS_ON = 2'h2,
		SPSUP_POS_DISTURB = 2'h3
	} spsup_pos_e;
	// Travel supervision state of one switching unit.
	typedef enum logic [1:0] {
		SPSUP_IDLE = 2'h0,
		SPSUP_MOVE_ON = 2'h1,
		SPSUP_MOVE_OFF = 2'h2
	} spsup_move_e;
endpackage : spsup_pkg

// ==== core/spsup_unit_if.sv ====
// Interface between the supervisor top and one switching unit.
`timescale 1ns/1ns
`default_nettype none
interface spsup_unit_if;
	import spsup_pkg::*;
	logic close_req, open_req;            // Command requests, level, taken only while idle.
	logic [31:0] t_on, t_off;             // Travel times in clock ticks.
	logic aux_on, aux_off;                // Auxiliary contact inputs.
	logic on_wired, off_wired;            // Which contacts are connected.
	logic withdrawn;                      // Control plug removed.
	spsup_pos_e pos;                      // Validated position code.
	logic fl_closed, fl_open, fl_transit, fl_disturbed;
	logic drive_close, drive_open;        // Command relay drives.
	logic single_mode;                    // Only one contact connected.
	logic ev_ok, ev_fail;                 // One-cycle travel outcome events.
	modport ctrl (output close_req, open_req, t_on, t_off, aux_on, aux_off, on_wired, off_wired, withdrawn,
		input pos, fl_closed, fl_open, fl_transit, fl_disturbed, drive_close, drive_open, single_mode, ev_ok, ev_fail);
	modport unit (input close_req, open_req, t_on, t_off, aux_on, aux_off, on_wired, off_wired, withdrawn,
		output pos, fl_closed, fl_open, fl_transit, fl_disturbed, drive_close, drive_open, single_mode, ev_ok, ev_fail);
endinterface : spsup_unit_if
`default_nettype wire

// ==== core/spsup_unit.sv ====
// Travel timer and position validation of one switching unit.
`timescale 1ns/1ns
`default_nettype none
module spsup_unit
	import spsup_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Link to the supervisor top.
	spsup_unit_if.unit uif
);

	// Returns the contact-derived end position for one direction, given both contacts and wiring.
	function automatic logic contact_sense(input logic act, input logic oth, input logic act_w, input logic oth_w);
		contact_sense = (act_w && oth_w) ? (act && !oth) : act_w ? act : oth_w ? !oth : 1'b0;
	endfunction : contact_sense

	spsup_move_e state;         // Travel state.
	spsup_move_e next_state;    // Next travel state.
	logic [31:0] timer;         // Remaining travel ticks.
	logic fail;                 // Last travel expired without feedback.

	wire logic contact_on = contact_sense(uif.aux_on, uif.aux_off, uif.on_wired, uif.off_wired);
	wire logic contact_off = contact_sense(uif.aux_off, uif.aux_on, uif.off_wired, uif.on_wired);
	wire logic moving = (state != SPSUP_IDLE);
	wire logic none_wired = !uif.on_wired && !uif.off_wired;
	wire logic done_ok = (state == SPSUP_MOVE_ON && contact_on) || (state == SPSUP_MOVE_OFF && contact_off);
	wire logic expired = moving && (timer == 32'h0) && !done_ok;
	wire logic start_on = !moving && !uif.withdrawn && uif.close_req;
	wire logic start_off = !moving && !uif.withdrawn && !uif.close_req && uif.open_req;
	wire logic [31:0] load_on = (uif.t_on == 32'h0) ? 32'h0 : uif.t_on - 32'h1;
	wire logic [31:0] load_off = (uif.t_off == 32'h0) ? 32'h0 : uif.t_off - 32'h1;

	// A removed plug aborts travel; a running travel ends on feedback or expiry.
	assign next_state = uif.withdrawn ? SPSUP_IDLE :
		(moving && (done_ok || expired)) ? SPSUP_IDLE :
		start_on ? SPSUP_MOVE_ON : start_off ? SPSUP_MOVE_OFF : state;

	// Position priority: no contact, plug removed, travel, failure, contacts.
	assign uif.pos = none_wired ? SPSUP_POS_DISTURB :
		uif.withdrawn ? SPSUP_POS_OFF :
		moving ? SPSUP_POS_INDET :
		fail ? SPSUP_POS_DISTURB :
		contact_on ? SPSUP_POS_ON :
		contact_off ? SPSUP_POS_OFF : SPSUP_POS_DISTURB;
	// Flags follow the code, so transit and disturbed never meet.
	assign uif.fl_closed = (uif.pos == SPSUP_POS_ON);
	assign uif.fl_open = (uif.pos == SPSUP_POS_OFF);
	assign uif.fl_transit = (uif.pos == SPSUP_POS_INDET);
	assign uif.fl_disturbed = (uif.pos == SPSUP_POS_DISTURB);
	// Drives stand only during travel and stop at once on feedback.
	assign uif.drive_close = (state == SPSUP_MOVE_ON) && !done_ok && !uif.withdrawn;
	assign uif.drive_open = (state == SPSUP_MOVE_OFF) && !done_ok && !uif.withdrawn;
	assign uif.single_mode = uif.on_wired ^ uif.off_wired;
	assign uif.ev_ok = moving && done_ok && !uif.withdrawn;
	assign uif.ev_fail = expired && !uif.withdrawn;

	// State, timer and failure latch.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= SPSUP_IDLE;
			timer <= 32'h0;
			fail <= 1'b0;
		end else begin
			state <= next_state;
			timer <= start_on ? load_on : start_off ? load_off : (timer != 32'h0) ? timer - 32'h1 : timer;
			fail <= (start_on || start_off) ? 1'b0 : (fail || uif.ev_fail);
		end
	end

	transit_excl_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) !(uif.fl_transit && uif.fl_disturbed))
		else $error("transit and disturbed both set");
	close_ok_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state == SPSUP_MOVE_ON && contact_on && !uif.withdrawn) |=> (state == SPSUP_IDLE && !uif.drive_close))
		else $error("close feedback did not end travel");
	open_fail_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state == SPSUP_MOVE_OFF && timer == 32'h0 && !contact_off && !uif.withdrawn) |=> (fail && !moving))
		else $error("open expiry did not flag failure");
	drive_len_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(moving && timer == 32'h0) |=> (!uif.drive_close && !uif.drive_open))
		else $error("drive held past travel time");
	withdrawn_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(uif.withdrawn && !none_wired) |-> (uif.pos == SPSUP_POS_OFF && !uif.drive_open && !uif.drive_close))
		else $error("withdrawn unit not forced open");
	withdrawn_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		uif.withdrawn |=> !moving)
		else $error("withdrawn unit accepted a command");
	unwired_dist_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		none_wired |-> uif.pos == SPSUP_POS_DISTURB)
		else $error("unwired unit not disturbed");
	timer_count_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(moving && timer != 32'h0 && next_state != SPSUP_IDLE) |=> timer == $past(timer) - 32'h1)
		else $error("travel timer did not count down");

endmodule : spsup_unit
`default_nettype wire

// ==== core/spsup_top.sv ====
// Switchgear position supervisor: register slave, interrupts and two switching units.
`include "spsup_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module spsup_top
	import spsup_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Avalon-MM register slave.
	input wire logic [`SPSUP_ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Auxiliary contacts of the switch (unit 0) and truck (unit 1).
	input wire logic sw_aux_on_i,
	input wire logic sw_aux_off_i,
	input wire logic trk_aux_on_i,
	input wire logic trk_aux_off_i,
	// Control plug sense and protection commands.
	input wire logic plug_removed_i,
	input wire logic prot_close_i,
	input wire logic prot_open_i,
	// Command relay drives.
	output logic sw_close_drive_o,
	output logic sw_open_drive_o,
	output logic trk_close_drive_o,
	output logic trk_open_drive_o,
	// Position and indications.
	output logic [1:0] sw_pos_o,
	output logic [1:0] trk_pos_o,
	output logic plug_withdrawn_o,
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Merges write data into an old word under the byte enables.
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		be_merge = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				be_merge[8*b +: 8] = wd[8*b +: 8];
			end
		end
	endfunction : be_merge

	////////////////////////////////////////////////////////////////////////////////
	// Register storage.

	logic [`SPSUP_CTRL_W-1:0] ctrl;              // Wiring, routing and assembly mode.
	logic [31:0] time_reg [`SPSUP_TIME_N];       // Travel times, close then open per unit.
	logic [`SPSUP_CMD_W-1:0] cmd_pulse;          // One-cycle software commands.
	logic [`SPSUP_IRQ_W-1:0] irq_stat;           // Sticky event bits.
	logic [`SPSUP_IRQ_W-1:0] irq_mask;           // Interrupt enables.
	logic plug_q;                                // Plug state seen last cycle.
	logic [31:0] status_q;                       // Registered status word.

	// Bus handshake: one wait cycle, then the request is accepted.
	wire logic bus_req = avs_read_i || avs_write_i;
	wire logic wr_fire = avs_write_i && !avs_waitrequest_o;
	wire logic rd_fire = avs_read_i && !avs_waitrequest_o;
	wire logic sel_ctrl = (avs_address_i == `SPSUP_REG_CTRL);
	wire logic sel_cmd = (avs_address_i == `SPSUP_REG_CMD);
	wire logic sel_time = (avs_address_i >= `SPSUP_REG_TIME0) && (avs_address_i <= `SPSUP_REG_TIME3)
		&& (avs_address_i[1:0] == 2'h0);
	wire logic sel_status = (avs_address_i == `SPSUP_REG_STATUS);
	wire logic sel_istat = (avs_address_i == `SPSUP_REG_IRQ_STAT);
	wire logic sel_imask = (avs_address_i == `SPSUP_REG_IRQ_MASK);
	wire logic [1:0] time_idx = 2'(avs_address_i[`SPSUP_ADDR_W-1:2] - `SPSUP_REG_TIME0 / 4);
	wire logic [31:0] wr_word = be_merge(32'h0, avs_writedata_i, avs_byteenable_i);
	// Merged words for the narrow registers; the spare upper bits are cut off when stored.
	wire logic [31:0] ctrl_wr = be_merge({22'h0, ctrl}, avs_writedata_i, avs_byteenable_i);
	wire logic [31:0] imask_wr = be_merge({27'h0, irq_mask}, avs_writedata_i, avs_byteenable_i);

	// Read selection; unmapped addresses read as zero.
	wire logic [31:0] rd_mux = sel_ctrl ? {22'h0, ctrl} :
		sel_time ? time_reg[time_idx] :
		sel_status ? status_q :
		sel_istat ? {27'h0, irq_stat} :
		sel_imask ? {27'h0, irq_mask} : 32'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Switching units.

	spsup_unit_if u_if [2] ();    // One link per unit.
	logic [1:0] ev_ok;             // Travel succeeded, per unit.
	logic [1:0] ev_fail;           // Travel expired, per unit.
	logic [7:0] unit_stat [2];     // Status byte per unit.
	spsup_pos_e unit_pos [2];      // Own position per unit.
	logic [1:0] drv_close;         // Close drives per unit.
	logic [1:0] drv_open;          // Open drives per unit.

	// Protection commands join the switch unit's requests only when routing is on.
	wire logic route_en = ctrl[`SPSUP_CTRL_ROUTE];
	wire logic [1:0] aux_on_in = {trk_aux_on_i, sw_aux_on_i};
	wire logic [1:0] aux_off_in = {trk_aux_off_i, sw_aux_off_i};
	wire logic [1:0] prot_close_in = {1'b0, prot_close_i && route_en};
	wire logic [1:0] prot_open_in = {1'b0, prot_open_i && route_en};

	for (genvar u = 0; u < 2; u++) begin : g_unit
		// Feed the unit its configuration, contacts and requests.
		assign u_if[u].close_req = cmd_pulse[2*u] || prot_close_in[u];
		assign u_if[u].open_req = cmd_pulse[2*u+1] || prot_open_in[u];
		assign u_if[u].t_on = time_reg[2*u];
		assign u_if[u].t_off = time_reg[2*u+1];
		assign u_if[u].aux_on = aux_on_in[u];
		assign u_if[u].aux_off = aux_off_in[u];
		assign u_if[u].on_wired = ctrl[`SPSUP_CTRL_UNIT_STRIDE*u + `SPSUP_CTRL_ON_WIRED];
		assign u_if[u].off_wired = ctrl[`SPSUP_CTRL_UNIT_STRIDE*u + `SPSUP_CTRL_OFF_WIRED];
		// Only the switch carries the plug; the truck itself is not forced.
		assign u_if[u].withdrawn = (u == 0) ? plug_removed_i : 1'b0;
		// Collect results.
		assign ev_ok[u] = u_if[u].ev_ok;
		assign ev_fail[u] = u_if[u].ev_fail;
		assign unit_pos[u] = u_if[u].pos;
		assign drv_close[u] = u_if[u].drive_close;
		assign drv_open[u] = u_if[u].drive_open;
		assign unit_stat[u] = {1'b0, u_if[u].single_mode, u_if[u].fl_disturbed, u_if[u].fl_transit,
			u_if[u].fl_open, u_if[u].fl_closed, u_if[u].pos};

		spsup_unit u_unit (
			.clk_i(clk_i),
			.reset_n_i(reset_n_i),
			.uif(u_if[u])
		);
	end

	// Composite position of the assembly: a removed plug wins, then any fault, then any travel, then both closed.
	wire logic any_dist = (unit_pos[0] == SPSUP_POS_DISTURB) || (unit_pos[1] == SPSUP_POS_DISTURB);
	wire logic any_indet = (unit_pos[0] == SPSUP_POS_INDET) || (unit_pos[1] == SPSUP_POS_INDET);
	wire logic both_on = (unit_pos[0] == SPSUP_POS_ON) && (unit_pos[1] == SPSUP_POS_ON);
	// A removed plug shows the switch's own forced position on both units.
	wire spsup_pos_e comp_pos = plug_removed_i ? unit_pos[0] :
		any_dist ? SPSUP_POS_DISTURB : any_indet ? SPSUP_POS_INDET :
		both_on ? SPSUP_POS_ON : SPSUP_POS_OFF;
	wire logic assy_mode = ctrl[`SPSUP_CTRL_ASSY];
	// A removed plug forces open even the composite view while the switch has a contact wired.
	wire spsup_pos_e shown_sw = assy_mode ? comp_pos : unit_pos[0];
	wire spsup_pos_e shown_trk = assy_mode ? comp_pos : unit_pos[1];

	// Events for the sticky status, including each plug change.
	wire logic plug_change = plug_q ^ plug_removed_i;
	wire logic [`SPSUP_IRQ_W-1:0] irq_events = {plug_change, ev_fail[1], ev_ok[1], ev_fail[0], ev_ok[0]};
	// Only the bits that were returned to software are cleared, so a fresh event survives.
	wire logic [`SPSUP_IRQ_W-1:0] irq_clear = (rd_fire && sel_istat) ? avs_readdata_o[`SPSUP_IRQ_W-1:0] :
		{`SPSUP_IRQ_W{1'b0}};
	wire logic [`SPSUP_IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_clear) | irq_events;
	wire logic [31:0] next_status = {15'h0, plug_removed_i, unit_stat[1], unit_stat[0]};

	////////////////////////////////////////////////////////////////////////////////
	// Bus handshake and read data.

	// Waitrequest drops for exactly one cycle per request; read data is captured with it.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h0;
		end else begin
			avs_waitrequest_o <= !(avs_waitrequest_o && bus_req);
			if (avs_waitrequest_o && avs_read_i) begin
				avs_readdata_o <= rd_mux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control registers.

	// Configuration writes take effect on the accepting edge.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl <= `SPSUP_CTRL_RST;
			irq_mask <= {`SPSUP_IRQ_W{1'b0}};
		end else if (wr_fire && sel_ctrl) begin
			ctrl <= ctrl_wr[`SPSUP_CTRL_W-1:0];
		end else if (wr_fire && sel_imask) begin
			irq_mask <= imask_wr[`SPSUP_IRQ_W-1:0];
		end
	end

	// Travel time table, addressed by index.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < `SPSUP_TIME_N; i++) begin
				time_reg[i] <= `SPSUP_TIME_RST;
			end
		end else if (wr_fire && sel_time) begin
			time_reg[time_idx] <= be_merge(time_reg[time_idx], avs_writedata_i, avs_byteenable_i);
		end
	end

	// Command writes become one-cycle requests; a busy or withdrawn unit ignores them.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cmd_pulse <= {`SPSUP_CMD_W{1'b0}};
		end else begin
			cmd_pulse <= (wr_fire && sel_cmd) ? wr_word[`SPSUP_CMD_W-1:0] : {`SPSUP_CMD_W{1'b0}};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status, interrupts and outputs.

	// Sticky interrupt bits; a set in the clearing cycle wins.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_stat <= {`SPSUP_IRQ_W{1'b0}};
			plug_q <= 1'b0;
			irq_o <= 1'b0;
			status_q <= 32'h0;
		end else begin
			irq_stat <= next_irq_stat;
			plug_q <= plug_removed_i;
			irq_o <= |(next_irq_stat & irq_mask);
			status_q <= next_status;
		end
	end

	// Output registers for drives and positions.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sw_close_drive_o <= 1'b0;
			sw_open_drive_o <= 1'b0;
			trk_close_drive_o <= 1'b0;
			trk_open_drive_o <= 1'b0;
			sw_pos_o <= SPSUP_POS_INDET;
			trk_pos_o <= SPSUP_POS_INDET;
			plug_withdrawn_o <= 1'b0;
		end else begin
			sw_close_drive_o <= drv_close[0];
			sw_open_drive_o <= drv_open[0];
			trk_close_drive_o <= drv_close[1];
			trk_open_drive_o <= drv_open[1];
			sw_pos_o <= shown_sw;
			trk_pos_o <= shown_trk;
			plug_withdrawn_o <= plug_removed_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	plug_flag_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		plug_removed_i |=> plug_withdrawn_o)
		else $error("plug withdrawn not indicated");
	plug_force_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(plug_removed_i && !assy_mode && (ctrl[1:0] != 2'h0)) |=> sw_pos_o == SPSUP_POS_OFF)
		else $error("withdrawn switch not shown open");
	assy_same_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		assy_mode |=> sw_pos_o == trk_pos_o)
		else $error("assembly units disagree");
	route_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(!route_en && cmd_pulse == 4'h0) |-> !u_if[0].close_req && !u_if[0].open_req)
		else $error("protection command routed while disabled");
	irq_level_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		##1 irq_o == |($past(next_irq_stat) & $past(irq_mask)))
		else $error("interrupt does not follow masked status");
	wait_one_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low for more than one cycle");

endmodule : spsup_top
`default_nettype wire

// ==== sim/spsup_gear_model.sv ====
// Switchgear model: moves its auxiliary contacts a few cycles after a relay drive.
`timescale 1ns/1ns
`default_nettype none
module spsup_gear_model (
	// Clock, reset and control.
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic stuck_i,
	// Relay drives in, contacts out.
	input wire logic close_drive_i,
	input wire logic open_drive_i,
	output logic aux_on_o,
	output logic aux_off_o
);
	logic [3:0] cnt; // Cycles since travel began.
	// Both contacts break on the first cycle of travel; a stuck gear never moves.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			aux_on_o <= 1'b0;
			aux_off_o <= 1'b1;
			cnt <= 4'h0;
		end else if (!stuck_i && ((close_drive_i && !aux_on_o) || (open_drive_i && !aux_off_o))) begin
			cnt <= cnt + 4'h1;
			if (cnt == 4'h2) begin
				aux_on_o <= close_drive_i;
				aux_off_o <= !close_drive_i;
				cnt <= 4'h0;
			end else if (cnt == 4'h0) begin
				aux_on_o <= 1'b0;
				aux_off_o <= 1'b0;
			end
		end
	end
endmodule : spsup_gear_model
`default_nettype wire

// ==== sim/test_switchgear_position_supervisor.sv ====
// Bench of the position supervisor: bus tasks and sequenced checks.
`timescale 1ns/1ns
`default_nettype none
module test_switchgear_position_supervisor;
	logic clk_i = 0, reset_n_i = 0, rd_i = 0, wr_i = 0, plug = 0, pc = 0, po = 0, stuck = 0;
	logic [5:0] adr = 6'h00;
	logic [31:0] wd = 32'h0, rdat, d;
	logic wq, swon, swoff, tkon, tkoff, swc, swo, tkc, tko, plw, irq;
	logic [1:0] swp, tkp;
	int n_mismatch = 0, compares = 0, cyc = 0, dlen = 0;
	// Device under test.
	spsup_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(adr), .avs_read_i(rd_i),
		.avs_write_i(wr_i), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wq), .sw_aux_on_i(swon), .sw_aux_off_i(swoff), .trk_aux_on_i(tkon),
		.trk_aux_off_i(tkoff), .plug_removed_i(plug), .prot_close_i(pc), .prot_open_i(po),
		.sw_close_drive_o(swc), .sw_open_drive_o(swo), .trk_close_drive_o(tkc), .trk_open_drive_o(tko),
		.sw_pos_o(swp), .trk_pos_o(tkp), .plug_withdrawn_o(plw), .irq_o(irq));
	// Switch and truck gear.
	spsup_gear_model u_sw (.clk_i(clk_i), .reset_n_i(reset_n_i), .stuck_i(stuck), .close_drive_i(swc),
		.open_drive_i(swo), .aux_on_o(swon), .aux_off_o(swoff));
	spsup_gear_model u_tk (.clk_i(clk_i), .reset_n_i(reset_n_i), .stuck_i(1'b0), .close_drive_i(tkc),
		.open_drive_i(tko), .aux_on_o(tkon), .aux_off_o(tkoff));
	////////////////////////////////////////////////////////////////////////////////
	// Clock, drive length counter and timeout.
	always #4 clk_i = !clk_i;
	always @(posedge clk_i) begin
		cyc++;
		dlen <= dlen + (swo === 1'b1);
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Compare one value.
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// One bus cycle, held until waitrequest is sampled low.
	task bus(input logic w, input logic [5:0] a, input logic [31:0] v);
		@(posedge clk_i);
		adr <= a;
		wd <= v;
		wr_i <= w;
		rd_i <= !w;
		do @(posedge clk_i); while (wq !== 1'b0);
		d = rdat;
		wr_i <= 1'b0;
		rd_i <= 1'b0;
	endtask : bus
	// Wait a bounded time for a switch position.
	task wsw(input logic [1:0] e);
		for (int i = 0; i < 40 && swp !== e; i++) @(posedge clk_i);
		chk(swp, e);
	endtask : wsw
	// Verdict.
	task stop_test();
		if (n_mismatch == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test
	////////////////////////////////////////////////////////////////////////////////
	// Test sequence.
	initial begin
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
		bus(0, 6'h00, 0); chk(d, 32'h033);
		bus(0, 6'h08, 0); chk(d, 32'h1000);
		bus(0, 6'h3C, 0); chk(d, 0);
		chk(swp, 2'h1);
		bus(1, 6'h08, 8); bus(1, 6'h0C, 6); bus(1, 6'h10, 8); bus(1, 6'h20, 32'h1F);
		bus(1, 6'h04, 1);
		for (int i = 0; i < 9 && swc !== 1'b1; i++) @(posedge clk_i);
		chk(swp, 2'h0);
		wsw(2'h2); chk(swc, 0); chk(irq, 1);
		bus(0, 6'h1C, 0); chk(d, 1);
		repeat (2) @(posedge clk_i); chk(irq, 0);
		stuck <= 1'b1;
		bus(1, 6'h04, 2); wsw(2'h3); chk(dlen, 6);
		bus(0, 6'h18, 0); chk(d, 32'h0923);
		bus(0, 6'h1C, 0); chk(d, 2);
		stuck <= 1'b0;
		bus(1, 6'h04, 4);
		for (int i = 0; i < 40 && tkp !== 2'h2; i++) @(posedge clk_i);
		chk(tkp, 2'h2); chk(tkc, 0);
		bus(1, 6'h00, 32'h233); repeat (3) @(posedge clk_i);
		chk(swp, 2'h3); chk(tkp, 2'h3);
		bus(1, 6'h00, 32'h033); plug <= 1'b1; repeat (3) @(posedge clk_i);
		chk(plw, 1); chk(swp, 2'h1);
		bus(1, 6'h04, 1); repeat (8) @(posedge clk_i); chk(swc, 0);
		plug <= 1'b0; bus(0, 6'h1C, 0); chk(d[4], 1);
		bus(1, 6'h00, 32'h133); po <= 1'b1;
		for (int i = 0; i < 9 && swo !== 1'b1; i++) @(posedge clk_i);
		chk(swo, 1); po <= 1'b0; wsw(2'h1);
		bus(1, 6'h00, 32'h031); bus(0, 6'h18, 0); chk(d[6], 1);
		chk(d[1:0], 2'h1);
		bus(1, 6'h00, 32'h030); wsw(2'h3);
		stop_test();
	end
endmodule : test_switchgear_position_supervisor
`default_nettype wire
